/* File: pkg/dclkm_pkg.sv */
// Constants and carrier types for the digital clock manager model.
// Assumes a single 50 MHz system clock; all pins are sampled on it.
package dclkm_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS       = 20;
	localparam int STOP_NS      = 20000;
	localparam int STOP_CYC     = (STOP_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOCK_PERIODS = 4;
	localparam int STEP_LAT     = 4;
	localparam int FB_TOL       = 2;
	// ----------------------------------------------------------------
	// Phase and synthesis
	// ----------------------------------------------------------------
	localparam int PHASE_SH      = 8;
	localparam int PHASE_MAX     = 255;
	localparam logic [7:0] M_DEF = 8'h04;
	localparam logic [7:0] D_DEF = 8'h01;
	// Divide factor is coded in half steps: 3 = 1.5, 32 = 16
	localparam logic [5:0] DIV2_MIN  = 6'h03;
	localparam logic [5:0] DIV2_HMAX = 6'h10;
	localparam logic [5:0] DIV2_IMIN = 6'h12;
	localparam logic [5:0] DIV2_MAX  = 6'h20;
	localparam logic [5:0] DIV2_DEF  = 6'h04;
	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              hf_mode;
		logic              var_mode;
		logic              fb_used;
		logic              wait_lock;
		logic [5:0]        divide_factor;
		logic [7:0]        mult_m;
		logic [7:0]        div_d;
		logic signed [8:0] phase_init;
	} dclkm_cfg_t;
	typedef struct packed {
		logic spare;
		logic synth_stopped;
		logic ref_stopped;
		logic ps_overflow;
	} dclkm_status_t;
endpackage

/* File: src/dclkm_top.sv */
// Digital clock manager, sampled model on the system clock.
// Assumes ref, feedback and step pins are synchronous to clk.
`timescale 1ns/100ps
module dclkm_top #(
	parameter int PW         = 16,
	parameter int FINE_RANGE = 255,
	parameter int STOP_LIM   = dclkm_pkg::STOP_CYC
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  ref_clock_in,
	input  wire logic                  feedback_clock_in,
	input  wire dclkm_pkg::dclkm_cfg_t cfg,
	input  wire logic                  step_clock,
	input  wire logic                  step_enable,
	input  wire logic                  step_direction,
	output logic                       step_done,
	output logic                       locked,
	output dclkm_pkg::dclkm_status_t   status,
	output logic                       config_release,
	output logic                       out_phase_zero,
	output logic                       out_phase_quarter,
	output logic                       out_phase_half,
	output logic                       out_phase_three_quarter,
	output logic                       doubled_out,
	output logic                       doubled_inverse_out,
	output logic                       divided_out,
	output logic                       synth_out,
	output logic                       synth_inverse_out
);
	import dclkm_pkg::*;

	if (PW < 4 || FINE_RANGE > PHASE_MAX || FINE_RANGE < 1 ||
	    STOP_LIM < 2 || STOP_LIM >= 2**PW) begin : g_bad_param
		$error("dclkm_top: unsupported parameters");
	end

	function automatic logic rise(input logic now, input logic prev);
		return now & ~prev;
	endfunction

	// ----------------------------------------------------------------
	// Reference period measurement and lock
	// ----------------------------------------------------------------
	logic          ref_p_r, fb_p_r, sclk_p_r;
	logic [PW-1:0] cnt_r, cnt_nxt, per_r, per_nxt;
	logic [2:0]    stab_r, stab_nxt;
	logic          fbok_r, fbok_nxt, lock_nxt, rstop_nxt;
	logic          per_ok;
	logic [PW-1:0] sp;
	logic          ref_rise, fb_rise;

	assign ref_rise = rise(ref_clock_in, ref_p_r);
	assign fb_rise  = rise(feedback_clock_in, fb_p_r);

	always_comb begin
		cnt_nxt  = cnt_r;
		per_nxt  = per_r;
		stab_nxt = stab_r;
		fbok_nxt = fbok_r;
		if (cnt_r != PW'(STOP_LIM))
			cnt_nxt = cnt_r + 1'b1;
		if (ref_rise) begin
			cnt_nxt = '0;
			per_nxt = cnt_r + 1'b1;
			if (per_nxt != per_r || cnt_r == PW'(STOP_LIM))
				stab_nxt = '0;
			else if (stab_r != 3'(LOCK_PERIODS))
				stab_nxt = stab_r + 1'b1;
		end
		rstop_nxt = (cnt_r == PW'(STOP_LIM));
		if (rstop_nxt)
			stab_nxt = '0;
		// De-skew check: feedback edge must land at the shifted zero point
		if (fb_rise)
			fbok_nxt = (sp < PW'(FB_TOL)) || (sp > per_r - PW'(FB_TOL));
		if (stab_nxt == '0)
			fbok_nxt = 1'b0;
		per_ok   = (stab_r == 3'(LOCK_PERIODS)) && !rstop_nxt;
		lock_nxt = per_ok && (fbok_r || !cfg.fb_used);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_p_r  <= 1'b0;
			fb_p_r   <= 1'b0;
			sclk_p_r <= 1'b0;
			cnt_r    <= '0;
			per_r    <= '0;
			stab_r   <= '0;
			fbok_r   <= 1'b0;
		end else begin
			ref_p_r  <= ref_clock_in;
			fb_p_r   <= feedback_clock_in;
			sclk_p_r <= step_clock;
			cnt_r    <= cnt_nxt;
			per_r    <= per_nxt;
			stab_r   <= stab_nxt;
			fbok_r   <= fbok_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Fine phase value and variable-mode stepping
	// ----------------------------------------------------------------
	logic signed [8:0] ph_r, ph_nxt, ph_try;
	logic [2:0]        bcnt_r, bcnt_nxt;
	logic              dir_r, dir_nxt, init_r, init_nxt;
	logic              ovf_r, ovf_nxt, done_r, done_nxt;
	logic [8:0]        lim;
	logic              take, srise;

	assign srise = rise(step_clock, sclk_p_r);
	assign take  = srise && step_enable && cfg.var_mode && init_r &&
	               bcnt_r == '0;
	// Variable mode centres zero skew, so only half the line each way
	assign lim   = cfg.var_mode ? 9'(FINE_RANGE / 2) : 9'(FINE_RANGE);

	always_comb begin
		ph_nxt   = ph_r;
		bcnt_nxt = bcnt_r;
		dir_nxt  = dir_r;
		init_nxt = 1'b1;
		ovf_nxt  = ovf_r;
		done_nxt = done_r;
		ph_try   = step_direction ? ph_r + 9'sd1 : ph_r - 9'sd1;
		if (!init_r || !cfg.var_mode) begin
			// Fixed value set at configuration, clamped to the line
			if (cfg.phase_init > $signed(lim))
				ph_nxt = $signed(lim);
			else if (cfg.phase_init < -$signed(lim))
				ph_nxt = -$signed(lim);
			else
				ph_nxt = cfg.phase_init;
		end
		if (srise)
			done_nxt = 1'b0;
		if (take) begin
			bcnt_nxt = 3'(STEP_LAT);
			dir_nxt  = step_direction;
		end else if (bcnt_r != '0) begin
			bcnt_nxt = bcnt_r - 1'b1;
		end
		if (bcnt_r == 3'h1) begin
			ph_try = dir_r ? ph_r + 9'sd1 : ph_r - 9'sd1;
			if (ph_try > $signed(lim) || ph_try < -$signed(lim)) begin
				ovf_nxt = 1'b1;
			end else begin
				ph_nxt  = ph_try;
				ovf_nxt = 1'b0;
			end
			done_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ph_r   <= '0;
			bcnt_r <= '0;
			dir_r  <= 1'b0;
			init_r <= 1'b0;
			ovf_r  <= 1'b0;
			done_r <= 1'b0;
		end else begin
			ph_r   <= ph_nxt;
			bcnt_r <= bcnt_nxt;
			dir_r  <= dir_nxt;
			init_r <= init_nxt;
			ovf_r  <= ovf_nxt;
			done_r <= done_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Shifted position within the reference period
	// ----------------------------------------------------------------
	logic signed [PW+9:0] prod;
	logic signed [PW+1:0] pos_s;

	always_comb begin
		prod  = ph_r * $signed({1'b0, per_r});
		pos_s = $signed({2'b00, cnt_r}) +
		        (PW+2)'(prod >>> PHASE_SH);
		if (pos_s < 0)
			pos_s = pos_s + $signed({2'b00, per_r});
		else if (pos_s >= $signed({2'b00, per_r}))
			pos_s = pos_s - $signed({2'b00, per_r});
		sp = PW'(pos_s);
	end

	// ----------------------------------------------------------------
	// Divided and synthesized clocks
	// ----------------------------------------------------------------
	logic [5:0]    f2;
	logic [PW+5:0] dv_r, dv_nxt, dv_len, dv_hi;
	logic [7:0]    mm, dd;
	logic [PW+8:0] acc_r, acc_nxt, thr;
	logic [PW-1:0] sidle_r, sidle_nxt;
	logic          sy_r, sy_nxt, sstop_nxt;

	always_comb begin
		f2 = cfg.divide_factor;
		if (!((f2 >= DIV2_MIN && f2 <= DIV2_HMAX) ||
		      (f2 >= DIV2_IMIN && f2 <= DIV2_MAX && !f2[0])))
			f2 = DIV2_DEF;
		dv_len = (PW+6)'(({{PW{1'b0}}, f2} * {6'h00, per_r}) >> 1);
		if (cfg.hf_mode && f2[0])
			dv_hi = (PW+6)'(({{PW{1'b0}}, f2 - 6'h01} *
			        {6'h00, per_r}) >> 2);
		else
			dv_hi = dv_len >> 1;
		dv_nxt = (dv_r + 1'b1 >= dv_len) ? '0 : dv_r + 1'b1;
		if (ref_rise && dv_r == '0)
			dv_nxt = '0;
		// Unset M or D falls back to the defaults
		mm  = (cfg.mult_m == '0) ? M_DEF : cfg.mult_m;
		dd  = (cfg.div_d == '0) ? D_DEF : cfg.div_d;
		thr = (PW+9)'({{PW{1'b0}}, dd} * {8'h00, per_r});
		acc_nxt   = acc_r + (PW+9)'({mm, 1'b0});
		sy_nxt    = sy_r;
		sidle_nxt = (sidle_r == PW'(STOP_LIM)) ? sidle_r : sidle_r + 1'b1;
		if (stab_r == '0) begin
			acc_nxt = '0;
		end else if (acc_nxt >= thr) begin
			acc_nxt   = acc_nxt - thr;
			sy_nxt    = !sy_r;
			sidle_nxt = '0;
		end
		sstop_nxt = (sidle_r == PW'(STOP_LIM));
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dv_r    <= '0;
			acc_r   <= '0;
			sy_r    <= 1'b0;
			sidle_r <= '0;
		end else begin
			dv_r    <= dv_nxt;
			acc_r   <= acc_nxt;
			sy_r    <= sy_nxt;
			sidle_r <= sidle_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	logic [PW-1:0] q1, q2, q3;
	logic          lf_ok;

	assign q2    = per_r >> 1;
	assign q1    = per_r >> 2;
	assign q3    = q1 + q2;
	assign lf_ok = per_ok && !cfg.hf_mode;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			locked                  <= 1'b0;
			config_release          <= 1'b0;
			status                  <= '0;
			step_done               <= 1'b0;
			out_phase_zero          <= 1'b0;
			out_phase_quarter       <= 1'b0;
			out_phase_half          <= 1'b0;
			out_phase_three_quarter <= 1'b0;
			doubled_out             <= 1'b0;
			doubled_inverse_out     <= 1'b0;
			divided_out             <= 1'b0;
			synth_out               <= 1'b0;
			synth_inverse_out       <= 1'b0;
		end else begin
			locked         <= lock_nxt;
			config_release <= !cfg.wait_lock || lock_nxt;
			status         <= '{spare: 1'b0, synth_stopped: sstop_nxt,
			                    ref_stopped: rstop_nxt,
			                    ps_overflow: ovf_nxt};
			step_done      <= done_nxt;
			// Coarse phases from the fine-shifted position
			// Clocks run once the period is stable, so feedback from them can lock
			out_phase_zero          <= per_ok && sp < q2;
			out_phase_half          <= per_ok && sp >= q2;
			out_phase_quarter       <= lf_ok && sp >= q1 && sp < q3;
			out_phase_three_quarter <= lf_ok && (sp < q1 || sp >= q3);
			doubled_out         <= lf_ok && (sp < q1 ||
			                       (sp >= q2 && sp < q3));
			doubled_inverse_out <= lf_ok && !(sp < q1 ||
			                       (sp >= q2 && sp < q3));
			divided_out       <= per_ok && dv_nxt < dv_hi;
			synth_out         <= per_ok && sy_nxt;
			synth_inverse_out <= per_ok && !sy_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	localparam int STEP_WAIT = STEP_LAT + 1;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_step_req;
		take;
	endsequence
	sequence s_step_end;
		##STEP_WAIT step_done;
	endsequence

	a_step_done_after: assert property (s_step_req |-> s_step_end)
		else $error("step done missing after step request");
	a_overflow_keeps: assert property (s_step_req ##0
		((dir_nxt ? ph_r + 9'sd1 : ph_r - 9'sd1) > $signed(lim))
		|-> ##STEP_WAIT (status.ps_overflow && ph_r == $past(ph_r, 5)))
		else $error("overflowing step changed phase or left flag low");
	a_phase_range: assert property (init_r |-> ph_r <= $signed(lim) &&
		ph_r >= -$signed(lim))
		else $error("phase value outside usable range");
	a_lock_after_rst: assert property (!$past(rst_n) |-> !locked)
		else $error("lock high right after reset");
	a_release_lock: assert property (cfg.wait_lock && config_release
		|-> locked)
		else $error("configuration released before lock");
	a_hf_outputs_off: assert property ($past(cfg.hf_mode) |->
		!doubled_out && !doubled_inverse_out && !out_phase_quarter &&
		!out_phase_three_quarter)
		else $error("high-frequency mode drove removed output");
	a_coarse_half: assert property (locked |->
		out_phase_half == !out_phase_zero)
		else $error("half phase not opposite zero phase");
	a_doubled_inv: assert property (locked && !$past(cfg.hf_mode) |->
		doubled_inverse_out != doubled_out)
		else $error("doubled inverse not opposite doubled");
	a_ref_stop_flag: assert property (cnt_r == PW'(STOP_LIM) |=>
		status.ref_stopped && !locked)
		else $error("stopped reference not reported");
endmodule

/* File: test/dclkm_stepper.sv */
// Partner model: user logic that issues fine phase steps.
// Assumes clk is the system clock; requests change on its falling edge.
`timescale 1ns/100ps
module dclkm_stepper (
	input  wire logic clk,
	input  wire logic step_done,
	output logic      step_clock,
	output logic      step_enable,
	output logic      step_direction
);
	initial begin
		step_clock = 1'b0;
		step_enable = 1'b0;
		step_direction = 1'b0;
	end
	// ----------------------------------------------------------------
	// One step request, returns cycles to done or -1
	// ----------------------------------------------------------------
	task automatic step(input logic dir, output int lat);
		lat = -1;
		@(negedge clk);
		step_enable = 1'b1;
		step_direction = dir;
		@(negedge clk);
		step_clock = 1'b1;
		for (int i = 1; i <= 20 && lat < 0; i++) begin
			@(negedge clk);
			step_clock = 1'b0;
			step_enable = 1'b0;
			step_direction = ~dir;
			if (step_done === 1'b1) begin
				lat = i;
			end
		end
	endtask
endmodule

/* File: test/dclkm_top_bench.sv */
// Bench for the clock manager: reference source, runs per setting.
// Assumes the package, the design and the step partner are compiled.
`timescale 1ns/100ps
module dclkm_top_bench;
	import dclkm_pkg::*;
	logic          clk = 1'b0;
	logic          rst_n = 1'b0;
	logic          ref_clk = 1'b0;
	logic          ref_run = 1'b0;
	logic          fb_on = 1'b0;
	dclkm_cfg_t    cfg = '0;
	dclkm_cfg_t    c;
	dclkm_status_t status;
	logic          step_clock;
	logic          step_enable;
	logic          step_direction;
	logic          step_done;
	logic          locked;
	logic          config_release;
	logic [8:0]    o;
	int            n_errors = 0;
	int            checks_done = 0;
	int            rc [9];
	int            hc [9];
	int            cnt = 0;
	int            lat;
	int            i;

	always #10 clk = ~clk;
	// Reference period of 16 system clocks
	always @(negedge clk) begin
		if (ref_run) begin
			cnt <= (cnt == 7) ? 0 : cnt + 1;
			if (cnt == 7) begin
				ref_clk <= ~ref_clk;
			end
		end
	end

	dclkm_top #(.FINE_RANGE(8), .STOP_LIM(50)) uut (
		.clk(clk), .rst_n(rst_n), .ref_clock_in(ref_clk),
		.feedback_clock_in(fb_on & o[0]),
		.cfg(cfg), .step_clock(step_clock), .step_enable(step_enable),
		.step_direction(step_direction), .step_done(step_done),
		.locked(locked), .status(status), .config_release(config_release),
		.out_phase_zero(o[0]), .out_phase_quarter(o[1]),
		.out_phase_half(o[2]), .out_phase_three_quarter(o[3]),
		.doubled_out(o[4]), .doubled_inverse_out(o[5]),
		.divided_out(o[6]), .synth_out(o[7]), .synth_inverse_out(o[8])
	);
	dclkm_stepper u_step (
		.clk(clk), .step_done(step_done), .step_clock(step_clock),
		.step_enable(step_enable), .step_direction(step_direction)
	);
	// ----------------------------------------------------------------
	// Compare and access tasks
	// ----------------------------------------------------------------
	task automatic chk_bit(input logic g, input logic e, input string m);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic chk_int(input int g, input int e, input string m);
		checks_done++;
		if (g != e) begin
			n_errors++;
			$display("[FAIL] %0t %s got %0d exp %0d", $time, m, g, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic restart(input dclkm_cfg_t k);
		@(negedge clk);
		cfg = k;
		ref_run = 1'b1;
		rst_n = 1'b0;
		repeat (5) @(negedge clk);
		chk_bit(locked, 1'b0, "lock in reset");
		chk_bit(|o, 1'b0, "clocks in reset");
		chk_bit(|status, 1'b0, "status in reset");
		rst_n = 1'b1;
		@(negedge clk);
		chk_bit(config_release, ~k.wait_lock, "release");
	endtask
	task automatic wait_lock(input logic e);
		for (i = 0; i < 300 && locked !== 1'b1; i++) begin
			@(negedge clk);
		end
		chk_bit(locked, e, "lock");
	endtask
	task automatic measure(input int n, input logic hf);
		logic [8:0] p;
		logic [3:0] zh;
		p = o;
		zh = '0;
		for (int k = 0; k < 9; k++) begin
			rc[k] = 0;
			hc[k] = 0;
		end
		for (int j = 0; j < n; j++) begin
			@(negedge clk);
			for (int k = 0; k < 9; k++) begin
				rc[k] += int'(o[k] & ~p[k]);
				hc[k] += int'(o[k]);
			end
			chk_bit($isunknown(o), 1'b0, "unknown clock");
			chk_bit(o[2], ~o[0], "half phase");
			chk_bit(o[5], hf ? 1'b0 : ~o[4], "doubled inverse");
			chk_bit(o[8], ~o[7], "synth inverse");
			chk_bit(o[3], hf ? 1'b0 : ~o[1], "three quarter");
			if (j >= 4) begin
				chk_bit(o[1], hf ? 1'b0 : zh[3], "quarter");
			end
			chk_bit(status.spare, 1'b0, "spare");
			zh = {zh[2:0], o[0]};
			p = o;
		end
	endtask
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		#(20 * 20000);
		n_errors++;
		$display("[FAIL] %0t watchdog", $time);
		tally_and_finish();
	end
	initial begin
		c = '0;
		c.var_mode = 1'b1;
		c.wait_lock = 1'b1;
		c.divide_factor = 6'h04;
		restart(c);
		chk_bit(config_release, 1'b0, "held");
		wait_lock(1'b1);
		@(negedge clk);
		chk_bit(config_release, 1'b1, "released");
		measure(128, 1'b0);
		chk_int(rc[0], 8, "zero rate");
		chk_int(hc[0], 64, "zero duty");
		chk_int(rc[4], 16, "doubled rate");
		chk_int(hc[4], 64, "doubled duty");
		chk_int(rc[6], 4, "divide 2 rate");
		chk_int(hc[6], 64, "divide 2 duty");
		chk_int(rc[7], 32, "synth default rate");
		chk_int(hc[7], 64, "synth duty");
		for (int s = 0; s < 4; s++) begin
			u_step.step(1'b1, lat);
			chk_int(lat, STEP_LAT + 1, "step done");
			chk_int(uut.ph_r, s + 1, "phase value");
			chk_bit(status.ps_overflow, 1'b0, "no overflow");
		end
		u_step.step(1'b1, lat);
		chk_int(lat, STEP_LAT + 1, "overflow done");
		chk_int(uut.ph_r, 4, "phase kept");
		chk_bit(status.ps_overflow, 1'b1, "overflow");
		u_step.step(1'b0, lat);
		chk_int(lat, STEP_LAT + 1, "down step");
		chk_int(uut.ph_r, 3, "phase down");
		chk_bit(status.ps_overflow, 1'b0, "overflow clear");
		ref_run = 1'b0;
		for (i = 0; i < 70 && status.ref_stopped !== 1'b1; i++) begin
			@(negedge clk);
		end
		chk_bit(status.ref_stopped, 1'b1, "ref stopped");
		chk_bit(locked, 1'b0, "lock lost");
		for (i = 0; i < 120 && status.synth_stopped !== 1'b1; i++) begin
			@(negedge clk);
		end
		chk_bit(status.synth_stopped, 1'b1, "synth stopped");
		$display("test lf_steps done");
		c = '0;
		c.divide_factor = 6'h12;
		c.mult_m = 8'h01;
		c.div_d = 8'h02;
		c.phase_init = 9'h00C;
		restart(c);
		wait_lock(1'b1);
		chk_int(uut.ph_r, 8, "fixed phase clamp");
		measure(288, 1'b0);
		chk_int(rc[6], 2, "divide 9 rate");
		chk_int(hc[6], 144, "divide 9 duty");
		chk_int(rc[7], 9, "synth m d rate");
		u_step.step(1'b1, lat);
		chk_int(lat, -1, "fixed mode step");
		$display("test lf_fixed done");
		c = '0;
		c.hf_mode = 1'b1;
		c.fb_used = 1'b1;
		c.divide_factor = 6'h03;
		fb_on = 1'b0;
		restart(c);
		wait_lock(1'b0);
		fb_on = 1'b1;
		wait_lock(1'b1);
		measure(96, 1'b1);
		chk_int(rc[0], 6, "hf zero rate");
		chk_int(rc[6], 4, "hf divide rate");
		chk_int(hc[6], 32, "hf divide duty");
		chk_int(rc[7], 24, "hf synth rate");
		chk_int(rc[4] + rc[1], 0, "hf removed");
		$display("test hf done");
		tally_and_finish();
	end
endmodule
